// ===== shared/uart_pins_pkg.sv
// Package with register map, field positions and reset values of the modem and serial pin block.
package uart_pins_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCH = 2;
  // Byte address layout: bit 5 picks the channel, bits 4:2 pick the register.
  localparam int CH_BIT = 5;
  localparam int IDX_LO = 2;
  localparam int IDX_HI = 4;
  localparam int TOP_LO = 6;
  localparam logic [2:0] IDX_MODEM_CTRL = 3'h0;
  localparam logic [2:0] IDX_ENH_FEAT = 3'h1;
  localparam logic [2:0] IDX_INT_ENABLE = 3'h2;
  localparam logic [2:0] IDX_PIN_STATUS = 3'h3;
  localparam logic [2:0] IDX_EVENT_STATUS = 3'h4;
  localparam logic [2:0] IDX_EVENT_MASK = 3'h5;
  localparam logic [2:0] IDX_LAST = 3'h5;
  // Modem control fields.
  localparam int MC_TERM_READY = 0;
  localparam int MC_REQ_SEND = 1;
  localparam int MC_INT_OUT_EN = 3;
  localparam int MC_INFRARED = 6;
  // Enhanced feature and interrupt enable fields for automatic flow control.
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  localparam int IE_AUTO_RTS = 6;
  localparam int IE_AUTO_CTS = 7;
  // Pin status and event fields share one layout.
  localparam int EV_CTS = 0;
  localparam int EV_DSR = 1;
  localparam int EV_RI = 2;
  localparam int EV_CD = 3;
  localparam int EV_RX_READY = 4;
  localparam int ST_TX_ALLOWED = 5;
  localparam int EV_W = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [EV_W-1:0] EV_RESET = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ===== src/uart_modem_serial_pins.sv
// Serial line and modem pin logic for two channels with an AXI4-Lite register slave.
`timescale 1ns/1ps

// Functional notes
// - Active-low receive-ready output mirrors receive status.
// - Modem bit 6 clear selects standard serial.
// - Standard transmit line idles and resets high.
// - Modem bit 6 set selects infrared data.
// - Infrared encoder and decoder idle low.
// - Request-to-send: general output or automatic flow.
// - Clear-to-send: general input or automatic gating.
// - Terminal-ready is a software-driven output.
// - Modem bit 3 set: interrupt driven, port2 low.
// - Modem bit 3 clear: interrupt released, port2 high.
module uart_modem_serial_pins
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uart_pins_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [uart_pins_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [uart_pins_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [uart_pins_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic serial_out_a,
  input wire logic serial_in_a,
  output logic request_to_send_n_a,
  input wire logic clear_to_send_n_a,
  output logic terminal_ready_n_a,
  input wire logic set_ready_n_a,
  input wire logic carrier_detect_n_a,
  input wire logic ring_indicator_n_a,
  output logic output_port2_n_a,
  output logic irq_out_a,
  output logic irq_out_oe_a,
  output logic rx_ready_n_a,
  input wire logic tx_bit_a,
  input wire logic ir_tx_bit_a,
  input wire logic tx_active_a,
  input wire logic rx_nonempty_a,
  input wire logic rx_above_trigger_a,
  input wire logic core_int_a,
  output logic rx_std_bit_a,
  output logic rx_ir_bit_a,
  output logic tx_allowed_a,
  output logic serial_out_b,
  input wire logic serial_in_b,
  output logic request_to_send_n_b,
  input wire logic clear_to_send_n_b,
  output logic terminal_ready_n_b,
  input wire logic set_ready_n_b,
  input wire logic carrier_detect_n_b,
  input wire logic ring_indicator_n_b,
  output logic output_port2_n_b,
  output logic irq_out_b,
  output logic irq_out_oe_b,
  output logic rx_ready_n_b,
  input wire logic tx_bit_b,
  input wire logic ir_tx_bit_b,
  input wire logic tx_active_b,
  input wire logic rx_nonempty_b,
  input wire logic rx_above_trigger_b,
  input wire logic core_int_b,
  output logic rx_std_bit_b,
  output logic rx_ir_bit_b,
  output logic tx_allowed_b
);
  import uart_pins_pkg::*;

  // Address decode shared by the write and read paths.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    addr_mapped = (addr[ADDR_W-1:TOP_LO] == '0) && (addr[IDX_HI:IDX_LO] <= IDX_LAST);
  endfunction

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pin bundles gathered into per-channel vectors, index 0 is channel A.
  wire logic [NCH-1:0] cts_n_v = {clear_to_send_n_b, clear_to_send_n_a};
  wire logic [NCH-1:0] dsr_n_v = {set_ready_n_b, set_ready_n_a};
  wire logic [NCH-1:0] cd_n_v = {carrier_detect_n_b, carrier_detect_n_a};
  wire logic [NCH-1:0] ri_n_v = {ring_indicator_n_b, ring_indicator_n_a};
  wire logic [NCH-1:0] sin_v = {serial_in_b, serial_in_a};
  wire logic [NCH-1:0] tx_bit_v = {tx_bit_b, tx_bit_a};
  wire logic [NCH-1:0] ir_bit_v = {ir_tx_bit_b, ir_tx_bit_a};
  wire logic [NCH-1:0] tx_act_v = {tx_active_b, tx_active_a};
  wire logic [NCH-1:0] rx_ne_v = {rx_nonempty_b, rx_nonempty_a};
  wire logic [NCH-1:0] rx_hi_v = {rx_above_trigger_b, rx_above_trigger_a};
  wire logic [NCH-1:0] core_int_v = {core_int_b, core_int_a};

  logic [7:0] mcr_reg [NCH];
  logic [7:0] efr_reg [NCH];
  logic [7:0] ier_reg [NCH];
  logic [EV_W-1:0] ev_mask_reg [NCH];
  logic [EV_W-1:0] ev_stat_reg [NCH];
  logic [EV_W-1:0] pins_prev_reg [NCH];
  logic [EV_W-1:0] pins_now [NCH];
  logic [NCH-1:0] ser_out_reg;
  logic [NCH-1:0] rts_n_reg;
  logic [NCH-1:0] dtr_n_reg;
  logic [NCH-1:0] rx_rdy_n_reg;
  logic [NCH-1:0] tx_ok_reg;
  logic [NCH-1:0] rx_std_reg;
  logic [NCH-1:0] rx_ir_reg;
  logic [NCH-1:0] irq_ch;

  // Write channel holding registers; address and data may arrive in either order.
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic wr_fire;
  logic wr_ch;
  logic [2:0] wr_idx;

  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
  assign wr_ch = aw_addr_reg[CH_BIT];
  assign wr_idx = aw_addr_reg[IDX_HI:IDX_LO];

  // Capture the write address and data, and answer once both are in.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= CTRL_RESET;
      w_lane_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held_reg <= 1'b1;
        w_byte_reg <= wdata[7:0];
        w_lane_reg <= wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // Control registers; only the addressed channel's copy ever changes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        mcr_reg[c] <= CTRL_RESET;
        efr_reg[c] <= CTRL_RESET;
        ier_reg[c] <= CTRL_RESET;
        ev_mask_reg[c] <= EV_RESET;
      end
    end
    else if (wr_fire && w_lane_reg && addr_mapped(aw_addr_reg))
    begin
      case (wr_idx)
        IDX_MODEM_CTRL: mcr_reg[wr_ch] <= w_byte_reg;
        IDX_ENH_FEAT: efr_reg[wr_ch] <= w_byte_reg;
        IDX_INT_ENABLE: ier_reg[wr_ch] <= w_byte_reg;
        IDX_EVENT_MASK: ev_mask_reg[wr_ch] <= w_byte_reg[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Current pin levels shown active high, for status reads and edge detection.
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      pins_now[c] = EV_RESET;
      pins_now[c][EV_CTS] = !cts_n_v[c];
      pins_now[c][EV_DSR] = !dsr_n_v[c];
      pins_now[c][EV_RI] = !ri_n_v[c];
      pins_now[c][EV_CD] = !cd_n_v[c];
      pins_now[c][EV_RX_READY] = rx_ne_v[c];
    end
  end

  // Sticky events: any pin change or receive data arrival; writing a one clears,
  // but an event in the same cycle wins so that it is never lost.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        ev_stat_reg[c] <= EV_RESET;
        pins_prev_reg[c] <= EV_RESET;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        logic [EV_W-1:0] clr;
        logic [EV_W-1:0] hit;
        clr = EV_RESET;
        if (wr_fire && w_lane_reg && (wr_idx == IDX_EVENT_STATUS) &&
            (wr_ch == 1'(c)) && addr_mapped(aw_addr_reg))
        begin
          clr = w_byte_reg[EV_W-1:0];
        end
        hit = pins_now[c] ^ pins_prev_reg[c];
        hit[EV_RX_READY] = pins_now[c][EV_RX_READY] && !pins_prev_reg[c][EV_RX_READY];
        pins_prev_reg[c] <= pins_now[c];
        ev_stat_reg[c] <= (ev_stat_reg[c] & ~clr) | hit;
      end
    end
  end

  // Read path answers one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= RDATA_ZERO;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      logic rc;
      rc = araddr[CH_BIT];
      rvalid <= 1'b1;
      rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata <= RDATA_ZERO;
      if (addr_mapped(araddr))
      begin
        case (araddr[IDX_HI:IDX_LO])
          IDX_MODEM_CTRL: rdata[7:0] <= mcr_reg[rc];
          IDX_ENH_FEAT: rdata[7:0] <= efr_reg[rc];
          IDX_INT_ENABLE: rdata[7:0] <= ier_reg[rc];
          IDX_PIN_STATUS: rdata[ST_TX_ALLOWED:0] <= {tx_ok_reg[rc], pins_now[rc]};
          IDX_EVENT_STATUS: rdata[EV_W-1:0] <= ev_stat_reg[rc];
          IDX_EVENT_MASK: rdata[EV_W-1:0] <= ev_mask_reg[rc];
          default: rdata <= RDATA_ZERO;
        endcase
      end
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
    end
  end

  assign arready = !rvalid;

  // Per-channel line and modem pin logic, one identical copy per channel.
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      wire logic ir_mode = mcr_reg[i][MC_INFRARED];
      wire logic auto_rts = efr_reg[i][EF_AUTO_RTS] && ier_reg[i][IE_AUTO_RTS];
      wire logic auto_cts = efr_reg[i][EF_AUTO_CTS] && ier_reg[i][IE_AUTO_CTS];

      // Line drivers; a reset or an idle line rests at the mode's own idle level.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ser_out_reg[i] <= 1'b1;
          rx_std_reg[i] <= 1'b1;
          rx_ir_reg[i] <= 1'b0;
        end
        else if (ir_mode)
        begin
          ser_out_reg[i] <= tx_act_v[i] ? ir_bit_v[i] : 1'b0;
          rx_std_reg[i] <= 1'b1;
          rx_ir_reg[i] <= sin_v[i];
        end
        else
        begin
          ser_out_reg[i] <= tx_act_v[i] ? tx_bit_v[i] : 1'b1;
          rx_std_reg[i] <= sin_v[i];
          rx_ir_reg[i] <= 1'b0;
        end
      end

      // Modem outputs and flow control. With automatic flow the software
      // request bit must already be set, otherwise the pin stays deasserted.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          rts_n_reg[i] <= 1'b1;
          dtr_n_reg[i] <= 1'b1;
          rx_rdy_n_reg[i] <= 1'b1;
          tx_ok_reg[i] <= 1'b1;
        end
        else
        begin
          rts_n_reg[i] <= !(mcr_reg[i][MC_REQ_SEND] && !(auto_rts && rx_hi_v[i]));
          dtr_n_reg[i] <= !mcr_reg[i][MC_TERM_READY];
          rx_rdy_n_reg[i] <= !rx_ne_v[i];
          tx_ok_reg[i] <= !auto_cts || !cts_n_v[i];
        end
      end

      // The channel interrupt ignores the enable bit; only the pin's output enable follows it.
      assign irq_ch[i] = core_int_v[i] || |(ev_stat_reg[i] & ev_mask_reg[i]);

      property p_idle_std;
        (!ir_mode && !tx_act_v[i]) |=> ser_out_reg[i];
      endproperty
      a_idle_std: assert property (p_idle_std) else $error("standard idle line not high");

      property p_std_data;
        (!ir_mode && tx_act_v[i]) |=> (ser_out_reg[i] == $past(tx_bit_v[i]));
      endproperty
      a_std_data: assert property (p_std_data) else $error("standard data not on line");

      property p_ir_data;
        (ir_mode && tx_act_v[i]) |=> (ser_out_reg[i] == $past(ir_bit_v[i]));
      endproperty
      a_ir_data: assert property (p_ir_data) else $error("infrared data not on line");

      property p_ir_idle;
        (ir_mode && !tx_act_v[i]) |=> (!ser_out_reg[i] && !rx_std_reg[i] == 1'b0);
      endproperty
      a_ir_idle: assert property (p_ir_idle) else $error("infrared idle not low");

      property p_rx_ready;
        $rose(rx_ne_v[i]) |=> !rx_rdy_n_reg[i] ##1 (rx_rdy_n_reg[i] == !$past(rx_ne_v[i]));
      endproperty
      a_rx_ready: assert property (p_rx_ready) else $error("receive ready pin wrong");

      property p_auto_rts;
        (auto_rts && rx_hi_v[i]) |=> rts_n_reg[i];
      endproperty
      a_auto_rts: assert property (p_auto_rts) else $error("auto request not withdrawn");

      property p_auto_cts;
        (auto_cts && cts_n_v[i]) |=> !tx_ok_reg[i];
      endproperty
      a_auto_cts: assert property (p_auto_cts) else $error("transmit not held by clear");

      property p_dtr;
        (wr_fire && w_lane_reg && wr_idx == IDX_MODEM_CTRL && wr_ch == 1'(i) &&
         addr_mapped(aw_addr_reg)) |=> ##1 (dtr_n_reg[i] == !$past(w_byte_reg[MC_TERM_READY], 2));
      endproperty
      a_dtr: assert property (p_dtr) else $error("terminal ready not following write");

      property p_int_enable;
        (wr_fire && w_lane_reg && wr_idx == IDX_MODEM_CTRL && wr_ch == 1'(i) &&
         addr_mapped(aw_addr_reg)) |=>
          (mcr_reg[i][MC_INT_OUT_EN] == $past(w_byte_reg[MC_INT_OUT_EN]));
      endproperty
      a_int_enable: assert property (p_int_enable) else $error("interrupt enable lost");

      property p_status_only;
        $changed(dsr_n_v[i]) |=> (ev_stat_reg[i][EV_DSR] && $stable(tx_ok_reg[i]));
      endproperty
      a_status_only: assert property (p_status_only) else $error("set-ready misbehaves");

      property p_isolated;
        (wr_fire && wr_ch != 1'(i)) |=> ($stable(mcr_reg[i]) && $stable(ier_reg[i]));
      endproperty
      a_isolated: assert property (p_isolated) else $error("channel written by other");
    end
  endgenerate

  // Pin mapping back to named ports.
  assign serial_out_a = ser_out_reg[0];
  assign serial_out_b = ser_out_reg[1];
  assign request_to_send_n_a = rts_n_reg[0];
  assign request_to_send_n_b = rts_n_reg[1];
  assign terminal_ready_n_a = dtr_n_reg[0];
  assign terminal_ready_n_b = dtr_n_reg[1];
  assign rx_ready_n_a = rx_rdy_n_reg[0];
  assign rx_ready_n_b = rx_rdy_n_reg[1];
  assign tx_allowed_a = tx_ok_reg[0];
  assign tx_allowed_b = tx_ok_reg[1];
  assign rx_std_bit_a = rx_std_reg[0];
  assign rx_std_bit_b = rx_std_reg[1];
  assign rx_ir_bit_a = rx_ir_reg[0];
  assign rx_ir_bit_b = rx_ir_reg[1];
  // Port2 and interrupt release track the enable bit; a user toggling port2
  // as a general output would also switch the interrupt pin off.
  assign output_port2_n_a = !mcr_reg[0][MC_INT_OUT_EN];
  assign output_port2_n_b = !mcr_reg[1][MC_INT_OUT_EN];
  assign irq_out_oe_a = mcr_reg[0][MC_INT_OUT_EN];
  assign irq_out_oe_b = mcr_reg[1][MC_INT_OUT_EN];
  assign irq_out_a = irq_ch[0];
  assign irq_out_b = irq_ch[1];
  assign irq = |irq_ch;
endmodule

// ===== testbench/line_partner.sv
// Far-end line transceiver model that drives the receive and modem inputs of both channels.
`timescale 1ns/1ps
module line_partner
(
  input wire logic [1:0] ir_mode,
  input wire logic [1:0] sending,
  input wire logic [1:0] bits,
  input wire logic [7:0] assert_pins,
  output logic [1:0] serial_in,
  output logic [7:0] pins_n
);
  // A silent standard line rests high and a silent infrared line rests low.
  always_comb serial_in = (sending & bits) | (~sending & ~ir_mode);

  // Modem lines are active low, so an asserted line is driven to zero.
  always_comb pins_n = ~assert_pins;
endmodule

// ===== testbench/uart_modem_serial_pins_test.sv
// Self-checking bench for the two-channel serial and modem pin block.
`timescale 1ns/1ps
module uart_modem_serial_pins_test;
  import uart_pins_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0] bresp, rresp, so, rts_n, dtr_n, op2_n, io, ioe, rdy_n, rxs, rxi, txok, si;
  logic [1:0] ir_mode, snd, bits, tx_bit, ir_bit, tx_act, rx_ne, rx_trig, cint;
  logic [7:0] asrt, pins_n;
  int n_fail, comparisons;

  uart_modem_serial_pins dut
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq),
    .serial_out_a(so[0]), .serial_in_a(si[0]), .request_to_send_n_a(rts_n[0]),
    .clear_to_send_n_a(pins_n[0]), .terminal_ready_n_a(dtr_n[0]), .set_ready_n_a(pins_n[1]),
    .carrier_detect_n_a(pins_n[3]), .ring_indicator_n_a(pins_n[2]),
    .output_port2_n_a(op2_n[0]), .irq_out_a(io[0]), .irq_out_oe_a(ioe[0]),
    .rx_ready_n_a(rdy_n[0]), .tx_bit_a(tx_bit[0]), .ir_tx_bit_a(ir_bit[0]),
    .tx_active_a(tx_act[0]), .rx_nonempty_a(rx_ne[0]), .rx_above_trigger_a(rx_trig[0]),
    .core_int_a(cint[0]), .rx_std_bit_a(rxs[0]), .rx_ir_bit_a(rxi[0]), .tx_allowed_a(txok[0]),
    .serial_out_b(so[1]), .serial_in_b(si[1]), .request_to_send_n_b(rts_n[1]),
    .clear_to_send_n_b(pins_n[4]), .terminal_ready_n_b(dtr_n[1]), .set_ready_n_b(pins_n[5]),
    .carrier_detect_n_b(pins_n[7]), .ring_indicator_n_b(pins_n[6]),
    .output_port2_n_b(op2_n[1]), .irq_out_b(io[1]), .irq_out_oe_b(ioe[1]),
    .rx_ready_n_b(rdy_n[1]), .tx_bit_b(tx_bit[1]), .ir_tx_bit_b(ir_bit[1]),
    .tx_active_b(tx_act[1]), .rx_nonempty_b(rx_ne[1]), .rx_above_trigger_b(rx_trig[1]),
    .core_int_b(cint[1]), .rx_std_bit_b(rxs[1]), .rx_ir_bit_b(rxi[1]), .tx_allowed_b(txok[1])
  );

  line_partner link
  (
    .ir_mode(ir_mode), .sending(snd), .bits(bits), .assert_pins(asrt), .serial_in(si),
    .pins_n(pins_n)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; ready is read a step after each edge, where it has settled.
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] rs);
    bit at, wt_, bt;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (int i = 0; i < 100; i++)
    begin
      #1;
      at = (awvalid && awready) || (arvalid && arready);
      wt_ = wvalid && wready;
      bt = (bready && bvalid) || (rready && rvalid);
      q = rdata;
      rs = wr ? bresp : rresp;
      @(posedge aclk);
      if (at)
      begin
        awvalid <= 1'h0;
        arvalid <= 1'h0;
      end
      if (wt_)
        wvalid <= 1'h0;
      if (bt)
      begin
        bready <= 1'h0;
        rready <= 1'h0;
        return;
      end
    end
    n_fail++;
    $display("Error at %0t: bus transfer timed out", $time);
    print_verdict();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic [31:0] q;
    logic [1:0] rs;
    axi(1'h1, a, d, q, rs);
    chk(rs, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic [31:0] q;
    logic [1:0] rs;
    axi(1'h0, a, 32'h0000_0000, q, rs);
    chk(rs, er);
    chk(q, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // Main sequence; channel A sits in bit 0 of each pair, channel B in bit 1.
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    {ir_mode, snd, bits, tx_bit, ir_bit, tx_act, rx_ne, rx_trig, cint} = 18'h0_0000;
    asrt = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    wt(0);
    chk(so, 2'h3);
    chk(op2_n, 2'h3);
    chk(ioe, 2'h0);
    chk(dtr_n, 2'h3);
    chk(rdy_n, 2'h3);
    rd(8'h00, 32'h0000_0000);
    @(posedge aclk);
    tx_act <= 2'h1;
    snd <= 2'h1;
    wt(1);
    chk(so, 2'h2);
    chk(rxs, 2'h2);
    @(posedge aclk);
    tx_act <= 2'h0;
    snd <= 2'h0;
    wt(1);
    chk(so, 2'h3);
    chk(rxs, 2'h3);
    wr(8'h00, 32'h0000_0040);
    ir_mode <= 2'h1;
    wt(1);
    chk(so, 2'h2);
    chk(rxi, 2'h0);
    chk(rxs, 2'h3);
    @(posedge aclk);
    tx_act <= 2'h3;
    ir_bit <= 2'h1;
    snd <= 2'h1;
    bits <= 2'h1;
    wt(1);
    chk(so, 2'h1);
    chk(rxi, 2'h1);
    wr(8'h00, 32'h0000_0003);
    ir_mode <= 2'h0;
    tx_act <= 2'h0;
    snd <= 2'h0;
    wt(1);
    chk(dtr_n, 2'h2);
    chk(rts_n, 2'h2);
    wr(8'h04, 32'h0000_00c0);
    wr(8'h08, 32'h0000_00c0);
    rx_trig <= 2'h1;
    wt(1);
    chk(rts_n, 2'h3);
    chk(txok, 2'h2);
    rd(8'h0c, 32'h0000_0000);
    @(posedge aclk);
    rx_trig <= 2'h0;
    asrt <= 8'h01;
    wt(2);
    chk(rts_n, 2'h2);
    chk(txok, 2'h3);
    rd(8'h0c, 32'h0000_0021);
    // Port2 is left alone except as the interrupt output enable.
    wr(8'h14, 32'h0000_0002);
    wr(8'h00, 32'h0000_000b);
    wt(0);
    chk(op2_n, 2'h2);
    chk(ioe, 2'h1);
    chk(irq, 1'h0);
    wr(8'h10, 32'h0000_0001);
    asrt <= 8'h0f;
    wt(2);
    chk(io, 2'h1);
    chk(irq, 1'h1);
    chk(txok, 2'h3);
    chk(rts_n, 2'h2);
    chk(so, 2'h3);
    rd(8'h10, 32'h0000_000e);
    rd(8'h0c, 32'h0000_002f);
    wr(8'h10, 32'h0000_0002);
    wt(0);
    chk(io, 2'h0);
    chk(irq, 1'h0);
    @(posedge aclk);
    cint <= 2'h2;
    wt(1);
    chk(io, 2'h2);
    chk(irq, 1'h1);
    wr(8'h00, 32'h0000_0003);
    cint <= 2'h0;
    wt(0);
    chk(op2_n, 2'h3);
    chk(ioe, 2'h0);
    @(posedge aclk);
    rx_ne <= 2'h2;
    wt(1);
    chk(rdy_n, 2'h1);
    wt(1);
    rd(8'h30, 32'h0000_0010);
    rd(8'h2c, 32'h0000_0030);
    wr(8'h20, 32'h0000_0001);
    wt(1);
    chk(dtr_n, 2'h0);
    chk(rts_n, 2'h2);
    wr(8'h40, 32'h0000_00ff, RESP_SLVERR);
    rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    rd(8'h00, 32'h0000_0003);
    print_verdict();
  end
endmodule
